// ==== pkg/cpmr_pkg.sv ====
// Constants and types for the processor programming-model register set
package cpmr_pkg;
    localparam int GPR_COUNT      = 32;
    localparam int DATA_W         = 32;
    localparam int GPR_IDX_W      = 5;
    localparam int SEG_COUNT      = 16;
    localparam int SEG_IDX_W      = 4;
    localparam int CF_FIELDS      = 8;
    localparam int CF_FIELD_W     = 4;
    localparam int CF_IDX_W       = 3;
    localparam int HALT_W         = 33;
    // Machine state bit positions
    localparam int MS_USER_BIT    = 14; // Set selects user level
    localparam int MS_FLOAT_BIT   = 13; // float_avail_bit
    // Implementation configuration bit positions
    localparam int IC_FETCH_COH   = 24;
    localparam int IC_BCAST       = 28;
    localparam logic [31:0] IC_RSVD_MASK  = 32'h6600_0000; // Bits 25-26 and 29-30
    localparam logic [31:0] IC_RESET      = 32'h0000_0000;
    localparam logic [31:0] MS_RESET      = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
    // Version identity, values arbitrary
    localparam logic [15:0] VERSION_NUM   = 16'h00A5;
    localparam logic [15:0] REVISION_NUM  = 16'h0011;
    // Special-register select codes for move to and from
    typedef enum logic [2:0] {
        CPMR_SPR_VERSION,
        CPMR_SPR_CONFIG,
        CPMR_SPR_CONDITION,
        CPMR_SPR_STATE,
        CPMR_SPR_NONE
    } cpmr_spr_t;
endpackage

// ==== src/cpmr_dual_seg.sv ====
// Segment register arrays, main and shadow copies loaded together
`timescale 1ns/1ps
module cpmr_dual_seg #(
    parameter int ENTRIES = cpmr_pkg::SEG_COUNT,
    parameter int IDX_W   = cpmr_pkg::SEG_IDX_W,
    parameter int W       = cpmr_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             sys_rst_i,
    // Load port
    input  wire logic             load_i,
    input  wire logic [IDX_W-1:0] load_idx_i,
    input  wire logic [W-1:0]     load_data_i,
    // Read ports
    input  wire logic [IDX_W-1:0] data_idx_i,
    input  wire logic [IDX_W-1:0] fetch_idx_i,
    output logic      [W-1:0]     data_seg_o,
    output logic      [W-1:0]     fetch_seg_o
);
    import cpmr_pkg::*;
    logic [W-1:0] main_reg   [ENTRIES];
    logic [W-1:0] shadow_reg [ENTRIES];

    // Both copies written at one index in one cycle
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < ENTRIES; i++)
            begin
                main_reg[i]   <= '0;
                shadow_reg[i] <= '0;
            end
        end
        else if (load_i)
        begin
            main_reg[load_idx_i]   <= load_data_i;
            shadow_reg[load_idx_i] <= load_data_i;
        end
    end

    // Registered read of each array
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            data_seg_o  <= '0;
            fetch_seg_o <= '0;
        end
        else
        begin
            data_seg_o  <= main_reg[data_idx_i];
            fetch_seg_o <= shadow_reg[fetch_idx_i];
        end
    end

    a_copies_agree: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (data_idx_i == fetch_idx_i) |=> (data_seg_o == fetch_seg_o))
        else $error("segment copies differ");
endmodule

// ==== src/cpmr_regs.sv ====
// Processor programming-model register set
`timescale 1ns/1ps
// Function
// - Operands come from registers or immediate; destination named separately.
// - Exactly two privilege levels: supervisor and user.
// - Privileged writes take no effect in user mode.
// - Thirty-two general registers of 32 bits each.
// - Condition register holds eight 4-bit fields, updated and tested.
// - Machine state is supervisor-only, saved on exception, restored on return.
// - Sixteen segment registers in main and shadow copies.
// - Segment load writes both copies at the same index.
// - Halt counter 33 bits; upper 32 count cycles before halt.
// - Config bit 24 drives fetch coherence attribute.
// - Config bit 28 enables address-only cache-operation broadcast.
// - Snoop ignores foreign cache-operation broadcasts.
// - Version reports number and revision; read-only.
// - Version register 32 bits, read-only, names model and revision.
module cpmr_regs
    import cpmr_pkg::*;
#(
    parameter int NGPR = cpmr_pkg::GPR_COUNT
) (
    // Clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        sys_rst_i,
    // Operand read ports
    input  wire logic [cpmr_pkg::GPR_IDX_W-1:0] src_a_idx_i,
    input  wire logic [cpmr_pkg::GPR_IDX_W-1:0] src_b_idx_i,
    input  wire logic                        use_imm_i,
    input  wire logic [cpmr_pkg::DATA_W-1:0] imm_i,
    output logic      [cpmr_pkg::DATA_W-1:0] opnd_a_o,
    output logic      [cpmr_pkg::DATA_W-1:0] opnd_b_o,
    // Result write port
    input  wire logic                        gpr_we_i,
    input  wire logic [cpmr_pkg::GPR_IDX_W-1:0] dst_idx_i,
    input  wire logic [cpmr_pkg::DATA_W-1:0] gpr_wdata_i,
    // Condition field update and test
    input  wire logic                        cf_we_i,
    input  wire logic [cpmr_pkg::CF_IDX_W-1:0] cf_idx_i,
    input  wire logic [cpmr_pkg::CF_FIELD_W-1:0] cf_wdata_i,
    input  wire logic                        cf_all_we_i,
    input  wire logic [cpmr_pkg::DATA_W-1:0] cf_all_wdata_i,
    input  wire logic [cpmr_pkg::CF_IDX_W-1:0] cf_test_idx_i,
    output logic      [cpmr_pkg::CF_FIELD_W-1:0] cf_test_o,
    // Special register move to and from
    input  wire logic                        spr_we_i,
    input  wire cpmr_pkg::cpmr_spr_t         spr_sel_i,
    input  wire logic [cpmr_pkg::DATA_W-1:0] spr_wdata_i,
    output logic      [cpmr_pkg::DATA_W-1:0] spr_rdata_o,
    output logic                             priv_fault_o,
    // Exception entry and return
    input  wire logic                        exc_take_i,
    input  wire logic                        exc_return_i,
    output logic                             user_mode_o,
    // Segment register load and lookup
    input  wire logic                        seg_load_i,
    input  wire logic [cpmr_pkg::SEG_IDX_W-1:0] seg_load_idx_i,
    input  wire logic [cpmr_pkg::DATA_W-1:0] seg_wdata_i,
    input  wire logic [cpmr_pkg::SEG_IDX_W-1:0] seg_data_idx_i,
    input  wire logic [cpmr_pkg::SEG_IDX_W-1:0] seg_fetch_idx_i,
    output logic      [cpmr_pkg::DATA_W-1:0] seg_data_o,
    output logic      [cpmr_pkg::DATA_W-1:0] seg_fetch_o,
    // Debug port halt counter
    input  wire logic                        dbg_load_i,
    input  wire logic [cpmr_pkg::HALT_W-1:0] dbg_wdata_i,
    output logic      [cpmr_pkg::HALT_W-1:0] halt_count_o,
    output logic                             core_halt_o,
    // Bus attributes and snoop
    input  wire logic                        fetch_txn_i,
    output logic                             fetch_coherent_o,
    input  wire logic                        cache_op_i,
    output logic                             addr_only_bcast_o,
    input  wire logic                        snoop_valid_i,
    input  wire logic                        snoop_is_cache_op_i,
    output logic                             snoop_accept_o
);
    import cpmr_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [DATA_W-1:0] gpr_reg [NGPR];
    logic [DATA_W-1:0] condition_fields_reg;
    logic [DATA_W-1:0] machine_state_reg;
    logic [DATA_W-1:0] saved_state_reg;
    logic [DATA_W-1:0] impl_config0_reg;
    logic [HALT_W-1:0] halt_cycle_counter_reg;
    logic              supervisor;
    logic              priv_write;
    logic              exc_active_reg;

    assign supervisor = ~machine_state_reg[MS_USER_BIT];
    assign user_mode_o = machine_state_reg[MS_USER_BIT];

    // Move-to for state and configuration is privileged
    assign priv_write   = spr_we_i && (spr_sel_i == CPMR_SPR_STATE
                                    || spr_sel_i == CPMR_SPR_CONFIG);
    assign priv_fault_o = priv_write && !supervisor;

    // ------------------------------------------------------------
    // General registers
    // ------------------------------------------------------------
    // Destination write separate from both sources
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < NGPR; i++)
            begin
                gpr_reg[i] <= '0;
            end
        end
        else if (gpr_we_i)
        begin
            gpr_reg[dst_idx_i] <= gpr_wdata_i;
        end
    end

    // Operand fetch, second source may be an immediate
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            opnd_a_o <= '0;
            opnd_b_o <= '0;
        end
        else
        begin
            opnd_a_o <= gpr_reg[src_a_idx_i];
            opnd_b_o <= use_imm_i ? imm_i : gpr_reg[src_b_idx_i];
        end
    end

    // ------------------------------------------------------------
    // Condition fields
    // ------------------------------------------------------------
    // Field 0 sits in the top nibble
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            condition_fields_reg <= ZERO_WORD;
        end
        else if (spr_we_i && spr_sel_i == CPMR_SPR_CONDITION)
        begin
            condition_fields_reg <= spr_wdata_i;
        end
        else if (cf_all_we_i)
        begin
            condition_fields_reg <= cf_all_wdata_i;
        end
        else if (cf_we_i)
        begin
            condition_fields_reg[(CF_FIELDS-1-int'(cf_idx_i))*CF_FIELD_W +: CF_FIELD_W]
                <= cf_wdata_i;
        end
    end

    // Branch test of one field
    assign cf_test_o =
        condition_fields_reg[(CF_FIELDS-1-int'(cf_test_idx_i))*CF_FIELD_W +: CF_FIELD_W];

    // ------------------------------------------------------------
    // Machine state with save and restore
    // ------------------------------------------------------------
    // Exception enters supervisor; return restores saved copy
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            machine_state_reg <= MS_RESET;
            saved_state_reg   <= MS_RESET;
            exc_active_reg    <= 1'b0;
        end
        else if (exc_take_i)
        begin
            saved_state_reg                <= machine_state_reg;
            machine_state_reg[MS_USER_BIT] <= 1'b0;
            exc_active_reg                 <= 1'b1;
        end
        else if (exc_return_i && supervisor)
        begin
            machine_state_reg <= saved_state_reg;
            exc_active_reg    <= 1'b0;
        end
        else if (priv_write && supervisor && spr_sel_i == CPMR_SPR_STATE)
        begin
            machine_state_reg <= spr_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // Implementation configuration
    // ------------------------------------------------------------
    // Reserved bits never stored
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            impl_config0_reg <= IC_RESET;
        end
        else if (priv_write && supervisor && spr_sel_i == CPMR_SPR_CONFIG)
        begin
            impl_config0_reg <= spr_wdata_i & ~IC_RSVD_MASK;
        end
    end

    // Bus attributes steered by configuration bits
    assign fetch_coherent_o  = fetch_txn_i && impl_config0_reg[IC_FETCH_COH];
    assign addr_only_bcast_o = cache_op_i && impl_config0_reg[IC_BCAST];
    assign snoop_accept_o    = snoop_valid_i && !snoop_is_cache_op_i;

    // ------------------------------------------------------------
    // Halt cycle counter
    // ------------------------------------------------------------
    // Upper field counts down each cycle until it reaches zero, then holds; low bit kept as loaded
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            halt_cycle_counter_reg <= '0;
        end
        else if (dbg_load_i)
        begin
            halt_cycle_counter_reg <= dbg_wdata_i;
        end
        else if (halt_cycle_counter_reg[HALT_W-1:1] != '0)
        begin
            halt_cycle_counter_reg[HALT_W-1:1] <=
                halt_cycle_counter_reg[HALT_W-1:1] - 32'h0000_0001;
        end
    end

    assign halt_count_o = halt_cycle_counter_reg;
    assign core_halt_o  = (halt_cycle_counter_reg[HALT_W-1:1] == '0);

    // ------------------------------------------------------------
    // Special register read
    // ------------------------------------------------------------
    // Version is constant; supervisor registers read zero in user mode
    always_comb
    begin
        case (spr_sel_i)
            CPMR_SPR_VERSION:   spr_rdata_o = {VERSION_NUM, REVISION_NUM};
            CPMR_SPR_CONFIG:    spr_rdata_o = supervisor ? impl_config0_reg : ZERO_WORD;
            CPMR_SPR_CONDITION: spr_rdata_o = condition_fields_reg;
            CPMR_SPR_STATE:     spr_rdata_o = supervisor ? machine_state_reg : ZERO_WORD;
            default:            spr_rdata_o = ZERO_WORD;
        endcase
    end

    // ------------------------------------------------------------
    // Segment arrays
    // ------------------------------------------------------------
    cpmr_dual_seg u_seg (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .load_i      (seg_load_i && supervisor),
        .load_idx_i  (seg_load_idx_i),
        .load_data_i (seg_wdata_i),
        .data_idx_i  (seg_data_idx_i),
        .fetch_idx_i (seg_fetch_idx_i),
        .data_seg_o  (seg_data_o),
        .fetch_seg_o (seg_fetch_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_user_no_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (priv_write && !supervisor && !exc_take_i && !exc_return_i)
        |=> $stable(machine_state_reg) && $stable(impl_config0_reg))
        else $error("privileged write took effect in user mode");
    a_state_restore: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (exc_take_i ##1 (exc_return_i && !exc_take_i))
        |=> machine_state_reg == $past(machine_state_reg, 2))
        else $error("state not restored on return");
    a_exc_supervisor: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        exc_take_i |=> !user_mode_o)
        else $error("exception did not enter supervisor");
    a_cfg_reserved: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (impl_config0_reg & IC_RSVD_MASK) == ZERO_WORD)
        else $error("reserved config bits set");
    a_halt_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (dbg_load_i && dbg_wdata_i[HALT_W-1:1] > 32'h0000_0002) ##1 !dbg_load_i [*2]
        |-> halt_count_o[HALT_W-1:1] == $past(dbg_wdata_i[HALT_W-1:1], 2) - 32'h0000_0001
            && halt_count_o[0] == $past(dbg_wdata_i[0], 2))
        else $error("halt counter did not count down");
    a_fetch_attr: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        fetch_coherent_o |-> impl_config0_reg[IC_FETCH_COH])
        else $error("coherence attribute without enable");
    a_bcast_attr: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (cache_op_i && impl_config0_reg[IC_BCAST]) |-> addr_only_bcast_o)
        else $error("broadcast missing");
    a_snoop_ignore: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        snoop_is_cache_op_i |-> !snoop_accept_o)
        else $error("foreign cache op snooped");
    a_cf_update: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (cf_we_i && !cf_all_we_i && !(spr_we_i && spr_sel_i == CPMR_SPR_CONDITION)
         && cf_test_idx_i == cf_idx_i)
        |=> cf_test_o == $past(cf_wdata_i) || cf_test_idx_i != $past(cf_idx_i))
        else $error("condition field not updated");
endmodule

// ==== test/cpmr_dbg_model.sv ====
// Debug controller model that loads the halt cycle counter
`timescale 1ns/1ps
module cpmr_dbg_model
(
    // Clock
    input  wire logic                   clk_sys_i,
    // Debug load port toward the core
    output logic                        dbg_load_o,
    output logic [cpmr_pkg::HALT_W-1:0] dbg_wdata_o
);
    import cpmr_pkg::*;

    //--------------------------------------------------------------
    // Load port driver
    //--------------------------------------------------------------
    // Port is idle from time zero
    initial
    begin
        dbg_load_o  = 1'b0;
        dbg_wdata_o = '0;
    end

    // One-cycle load; the data is held through the edge that takes it
    task automatic load(input logic [31:0] cnt, input logic low);
        @(negedge clk_sys_i);
        dbg_load_o  = 1'b1;
        dbg_wdata_o = {cnt, low};
        @(negedge clk_sys_i);
        dbg_load_o  = 1'b0;
        dbg_wdata_o = ~dbg_wdata_o; // Released data must not look valid
    endtask
endmodule

// ==== test/test_cpu_programming_model_regs.sv ====
// Self-checking bench for the programming-model register set
`timescale 1ns/1ps
module test_cpu_programming_model_regs;
    import cpmr_pkg::*;

    //--------------------------------------------------------------
    // Signals
    //--------------------------------------------------------------
    logic        clk_sys_i, sys_rst_i, use_imm_i, gpr_we_i, cf_we_i;
    logic        cf_all_we_i, spr_we_i, exc_take_i, exc_return_i;
    logic        seg_load_i, fetch_txn_i, cache_op_i, snoop_valid_i;
    logic        snoop_is_cache_op_i, dbg_load_i, priv_fault_o;
    logic        user_mode_o, core_halt_o, fetch_coherent_o;
    logic        addr_only_bcast_o, snoop_accept_o;
    logic [4:0]  src_a_idx_i, src_b_idx_i, dst_idx_i;
    logic [31:0] imm_i, gpr_wdata_i, cf_all_wdata_i, spr_wdata_i;
    logic [31:0] seg_wdata_i, opnd_a_o, opnd_b_o, spr_rdata_o;
    logic [31:0] seg_data_o, seg_fetch_o;
    logic [2:0]  cf_idx_i, cf_test_idx_i;
    logic [3:0]  cf_wdata_i, cf_test_o;
    logic [3:0]  seg_load_idx_i, seg_data_idx_i, seg_fetch_idx_i;
    logic [32:0] dbg_wdata_i, halt_count_o;
    cpmr_spr_t   spr_sel_i;
    int          err_count = 0;
    int          tests_run = 0;

    // Design and debug controller model
    cpmr_regs DUT (.*);
    cpmr_dbg_model u_dbg (
        .clk_sys_i  (clk_sys_i),
        .dbg_load_o (dbg_load_i),
        .dbg_wdata_o(dbg_wdata_i)
    );

    // 50 MHz clock
    initial
    begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    //--------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------
    task automatic cyc;
        @(negedge clk_sys_i);
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    //--------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------
    // Back-to-back writes to registers 31 and 3, then operand reads
    task automatic t_gpr;
        gpr_we_i = 1'b1;
        dst_idx_i = 5'h1F;
        gpr_wdata_i = 32'hA5C3_0F1E;
        cyc;
        dst_idx_i = 5'h03;
        gpr_wdata_i = 32'h1234_5678;
        cyc;
        gpr_we_i = 1'b0;
        src_a_idx_i = 5'h03;
        src_b_idx_i = 5'h1F;
        cyc;
        chk(opnd_a_o, 32'h1234_5678, "source a");
        chk(opnd_b_o, 32'hA5C3_0F1E, "source b");
        use_imm_i = 1'b1;
        imm_i = 32'h0000_0FF0;
        src_a_idx_i = 5'h1F;
        cyc;
        chk(opnd_b_o, 32'h0000_0FF0, "immediate");
        chk(opnd_a_o, 32'hA5C3_0F1E, "source a top");
        use_imm_i = 1'b0;
    endtask

    // Whole write beats a field write in the same cycle
    task automatic t_cond;
        cf_all_we_i = 1'b1;
        cf_all_wdata_i = 32'h1234_5678;
        cf_we_i = 1'b1;
        cf_wdata_i = 4'hF;
        cyc;
        cf_all_we_i = 1'b0;
        cf_idx_i = 3'h7;
        cf_wdata_i = 4'hC;
        #1 chk(cf_test_o, 4'h1, "top field");
        cf_test_idx_i = 3'h7;
        cyc;
        cf_we_i = 1'b0;
        spr_sel_i = CPMR_SPR_CONDITION;
        #1 chk(cf_test_o, 4'hC, "low field");
        chk(spr_rdata_o, 32'h1234_567C, "condition word");
    endtask

    // Version, configuration bits and snoop filter in supervisor mode
    task automatic t_cfg;
        spr_we_i = 1'b1;
        spr_sel_i = CPMR_SPR_CONFIG;
        spr_wdata_i = 32'hFFFF_FFFF;
        cyc;
        spr_sel_i = CPMR_SPR_VERSION;
        spr_wdata_i = 32'h0000_0000;
        cyc;
        spr_we_i = 1'b0;
        #1 chk(spr_rdata_o, {VERSION_NUM, REVISION_NUM}, "version");
        spr_sel_i = CPMR_SPR_CONFIG;
        fetch_txn_i = 1'b1;
        cache_op_i = 1'b1;
        snoop_valid_i = 1'b1;
        snoop_is_cache_op_i = 1'b1;
        #1 chk(spr_rdata_o, 32'h99FF_FFFF, "reserved bits");
        chk(snoop_accept_o, 1'b0, "foreign cache op");
        snoop_is_cache_op_i = 1'b0;
        spr_we_i = 1'b1;
        spr_wdata_i = 32'h0100_0000;
        #1 chk(snoop_accept_o, 1'b1, "plain snoop");
        chk(priv_fault_o, 1'b0, "supervisor write allowed");
        cyc;
        spr_we_i = 1'b0;
        #1 chk(fetch_coherent_o, 1'b1, "fetch coherence");
        chk(addr_only_bcast_o, 1'b0, "broadcast off");
        spr_wdata_i = 32'h1000_0000;
        spr_we_i = 1'b1;
        cyc;
        spr_we_i = 1'b0;
        #1 chk(addr_only_bcast_o, 1'b1, "broadcast on");
        chk(fetch_coherent_o, 1'b0, "coherence off");
        spr_wdata_i = 32'h0100_0000;
        spr_we_i = 1'b1;
        cyc;
        spr_we_i = 1'b0;
    endtask

    // One load reaches both copies at the same index
    task automatic t_seg;
        seg_load_i = 1'b1;
        seg_load_idx_i = 4'hF;
        seg_wdata_i = 32'hC0DE_5EF1;
        cyc;
        seg_load_i = 1'b0;
        seg_data_idx_i = 4'hF;
        seg_fetch_idx_i = 4'hF;
        cyc;
        chk(seg_data_o, 32'hC0DE_5EF1, "data copy");
        chk(seg_fetch_o, 32'hC0DE_5EF1, "fetch copy");
    endtask

    // User level refuses privileged writes; exceptions save and restore
    task automatic t_priv;
        spr_sel_i = CPMR_SPR_STATE;
        spr_we_i = 1'b1;
        spr_wdata_i = 32'h0000_4000;
        cyc;
        #1 chk(user_mode_o, 1'b1, "user level");
        chk(priv_fault_o, 1'b1, "state write refused");
        spr_sel_i = CPMR_SPR_CONFIG;
        spr_wdata_i = 32'hFFFF_FFFF;
        seg_load_i = 1'b1;
        seg_load_idx_i = 4'h0;
        seg_wdata_i = 32'hFFFF_FFFF;
        #1 chk(spr_rdata_o, 32'h0000_0000, "config hidden");
        cyc;
        spr_we_i = 1'b0;
        seg_load_i = 1'b0;
        seg_data_idx_i = 4'h0;
        exc_take_i = 1'b1;
        cyc;
        exc_take_i = 1'b0;
        #1 chk(user_mode_o, 1'b0, "exception entry");
        chk(spr_rdata_o, 32'h0100_0000, "config kept");
        chk(seg_data_o, 32'h0000_0000, "segment kept");
        exc_return_i = 1'b1;
        cyc;
        exc_return_i = 1'b0;
        #1 chk(user_mode_o, 1'b1, "state restored");
        exc_take_i = 1'b1;
        cyc;
        exc_take_i = 1'b0;
        spr_sel_i = CPMR_SPR_STATE;
        #1 chk(spr_rdata_o[MS_USER_BIT], 1'b0, "supervisor state");
    endtask

    // Upper field counts down to zero and halts; the low bit is kept
    task automatic t_halt;
        u_dbg.load(32'h0000_0005, 1'b1);
        for (int i = 5; i >= 0; i--)
        begin
            #1 chk(halt_count_o, {32'(i), 1'b1}, "countdown");
            chk(core_halt_o, (i == 0), "halt flag");
            cyc;
        end
        chk(halt_count_o, 33'h0_0000_0001, "held at zero");
    endtask

    //--------------------------------------------------------------
    // Main sequence and watchdog
    //--------------------------------------------------------------
    initial
    begin
        {use_imm_i, gpr_we_i, cf_we_i, cf_all_we_i, spr_we_i, exc_take_i} = '0;
        {exc_return_i, seg_load_i, fetch_txn_i, cache_op_i} = '0;
        {snoop_valid_i, snoop_is_cache_op_i, src_a_idx_i, src_b_idx_i} = '0;
        {dst_idx_i, imm_i, gpr_wdata_i, cf_all_wdata_i, spr_wdata_i} = '0;
        {seg_wdata_i, cf_idx_i, cf_test_idx_i, cf_wdata_i} = '0;
        {seg_load_idx_i, seg_data_idx_i, seg_fetch_idx_i} = '0;
        spr_sel_i = CPMR_SPR_NONE;
        sys_rst_i = 1'b1;
        repeat (20) cyc;
        sys_rst_i = 1'b0;
        cyc;
        chk(core_halt_o, 1'b1, "halt after reset");
        chk(user_mode_o, 1'b0, "supervisor after reset");
        t_gpr;
        t_cond;
        t_cfg;
        t_seg;
        t_priv;
        t_halt;
        summarize;
    end

    // Cuts a hang short well past the expected run length
    initial
    begin
        repeat (2000) @(posedge clk_sys_i);
        err_count++;
        summarize;
    end
endmodule
